// ---- design/sbig_map.vh ----
// register offsets, field positions, reset values and frame lengths of the break/idle transmitter
`ifndef SBIG_MAP_VH
`define SBIG_MAP_VH
`define SBIG_OFF_CTRL 4'h0
`define SBIG_OFF_BAUD 4'h4
`define SBIG_OFF_STAT 4'h8
`define SBIG_OFF_DATA 4'hC
`define SBIG_CTRL_TE 0
`define SBIG_CTRL_SBK 1
`define SBIG_CTRL_M 2
`define SBIG_CTRL_LINE 3
`define SBIG_CTRL_RST 4'h0
`define SBIG_BAUD_RST 16'h0363
`define SBIG_BRK_SCI8 5'h0A
`define SBIG_BRK_SCI9 5'h0B
`define SBIG_BRK_LIN 5'h0D
`define SBIG_IDLE8 5'h0A
`define SBIG_IDLE9 5'h0B
`endif

// ---- design/sbig_baud_tick.v ----
// baud tick divider: one pulse per bit time
`timescale 1ns/1ns
module sbig_baud_tick #(
  parameter WIDTH = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [WIDTH-1:0] divisor_i,
  output reg tick_o
);
  reg [WIDTH-1:0] cnt;
  // count restarts whenever the transmitter idles so bits align to a start
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt >= divisor_i) begin
      cnt <= {WIDTH{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule // sbig_baud_tick

// ---- design/sbig_shift.v ----
// shift register holding the current frame pattern, lsb first
`timescale 1ns/1ns
module sbig_shift (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [12:0] pattern_i,
  input wire shift_i,
  output wire line_o
);
  reg [12:0] sreg;
  // ones shift in so the line falls back to idle-high
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sreg <= 13'h1FFF;
    end else if (load_i) begin
      sreg <= pattern_i;
    end else if (shift_i) begin
      sreg <= {1'b1, sreg[12:1]};
    end
  end
  assign line_o = sreg[0];
endmodule // sbig_shift

// ---- design/sbig_tx.v ----
// break and idle frame transmitter with wishbone control registers
`timescale 1ns/1ns
`include "sbig_map.vh"
// Functional notes
// - set then clear break sends one break
// - 8-bit frames without line enable give 10-bit break
// - 9-bit frames give 11-bit break
// - held break request repeats break characters
// - line enable with 8-bit means lin master
// - lin master break lasts 13 bits
// - enable off-then-on queues one idle character
// - idle ahead of break is 10 bits with 8-bit frames, 11 bits with 9-bit frames
module sbig_tx #(
  parameter BAUD_W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg tx_data_o
);
  // sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_IDLEC = 3'h1;
  localparam ST_BRK = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_DATA = 3'h4;

  // control bits as software last wrote them
  reg transmitter_enable;
  reg send_break_request;
  reg word_nine;
  reg line_enable;
  reg [BAUD_W-1:0] baud_div;
  // requests waiting for the sequencer
  reg idle_pend;
  reg brk_pend;
  reg data_pend;
  reg [8:0] data_hold;
  // sequencer and frame shifter control
  reg [2:0] state;
  reg [4:0] bit_cnt;
  reg load;
  reg [12:0] pattern;
  reg [15:0] brk_count;
  wire tick;
  wire line;
  // bus decode
  wire req;
  wire rd_req;
  wire wr_req;
  wire wr_ctrl;
  wire wr_baud;
  wire wr_data;
  wire new_te;
  wire new_sbk;
  // sequencer decode
  wire lin_master;
  wire seq_free;
  wire start_idle;
  wire start_brk;
  wire start_data;
  wire [31:0] ctrl_word;
  wire [31:0] stat_word;

  // break length from mode; lin master wins over word length
  function [4:0] brk_len;
    input lin;
    input nine;
    begin
      if (lin) brk_len = `SBIG_BRK_LIN;
      else if (nine) brk_len = `SBIG_BRK_SCI9;
      else brk_len = `SBIG_BRK_SCI8;
    end
  endfunction

  // bit times of an idle or a data character for the word length
  function [4:0] frame_len;
    input nine;
    begin
      if (nine) frame_len = `SBIG_IDLE9;
      else frame_len = `SBIG_IDLE8;
    end
  endfunction

  // break pattern: low len bits zero, ones above them
  // the shifter itself returns the line high after exactly len bits,
  // so no reload edge stretches the break by a clock
  function [12:0] brk_pattern;
    input [4:0] len;
    begin
      brk_pattern = ~((13'h0001 << len) - 13'h0001);
    end
  endfunction

  // data frame: start bit low, data lsb first, stop bits high above
  function [12:0] data_pattern;
    input nine;
    input [8:0] hold;
    begin
      if (nine) data_pattern = {3'h7, hold, 1'b0};
      else data_pattern = {4'hF, hold[7:0], 1'b0};
    end
  endfunction

  // bus request decode; ack low keeps one request from being taken twice
  assign req = cyc_i & stb_i & ~ack_o;
  assign rd_req = req & ~we_i;
  assign wr_req = req & we_i;
  assign wr_ctrl = wr_req & sel_i[0] & (adr_i == `SBIG_OFF_CTRL);
  assign wr_baud = wr_req & (adr_i == `SBIG_OFF_BAUD);
  assign wr_data = wr_req & sel_i[0] & (adr_i == `SBIG_OFF_DATA);
  assign new_te = dat_i[`SBIG_CTRL_TE];
  assign new_sbk = dat_i[`SBIG_CTRL_SBK];

  // readable words
  assign ctrl_word = {28'h0000000, line_enable, word_nine, send_break_request,
                      transmitter_enable};
  assign stat_word = {brk_count, 8'h00, lin_master, idle_pend, brk_pend, data_pend,
                      1'b0, state};

  // sequencer start decode; idle first, then break, then data
  assign lin_master = line_enable & ~word_nine;
  assign seq_free = (state == ST_IDLE) & transmitter_enable;
  assign start_idle = seq_free & idle_pend;
  assign start_brk = seq_free & ~idle_pend & (brk_pend | send_break_request);
  assign start_data = seq_free & ~idle_pend & ~brk_pend & ~send_break_request & data_pend;

  sbig_baud_tick #(.WIDTH(BAUD_W)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state != ST_IDLE),
    .divisor_i(baud_div),
    .tick_o(tick)
  );

  sbig_shift u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load),
    .pattern_i(pattern),
    .shift_i(tick),
    .line_o(line)
  );

  // handshake: one ack per taken request, dropped the cycle after
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // read mux: registered so data stands with ack, unmapped reads zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_req) begin
      case (adr_i)
        `SBIG_OFF_CTRL: dat_o <= ctrl_word;
        `SBIG_OFF_BAUD: dat_o <= {{(32-BAUD_W){1'b0}}, baud_div};
        `SBIG_OFF_STAT: dat_o <= stat_word;
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // control bits; byte 0 only, the other lanes are ignored
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      transmitter_enable <= 1'b0;
      send_break_request <= 1'b0;
      word_nine <= 1'b0;
      line_enable <= 1'b0;
    end else if (wr_ctrl) begin
      transmitter_enable <= new_te;
      send_break_request <= new_sbk;
      word_nine <= dat_i[`SBIG_CTRL_M];
      line_enable <= dat_i[`SBIG_CTRL_LINE];
    end
  end

  // baud divisor per byte lane; a new value applies at once, to the bit in progress
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_div <= `SBIG_BAUD_RST;
    end else if (wr_baud) begin
      if (sel_i[0]) baud_div[7:0] <= dat_i[7:0];
      if (sel_i[1]) baud_div[BAUD_W-1:8] <= dat_i[BAUD_W-1:8];
    end
  end

  // data byte, ninth bit only when lane 1 is written too
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_hold <= 9'h000;
    end else if (wr_data) begin
      data_hold <= {sel_i[1] & dat_i[8], dat_i[7:0]};
    end
  end

  // rising enable queues an idle; set wins over the sequencer taking it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_pend <= 1'b0;
    end else if (wr_ctrl && new_te && !transmitter_enable) begin
      idle_pend <= 1'b1;
    end else if (start_idle) begin
      idle_pend <= 1'b0;
    end
  end

  // only the rising edge of the request queues a break, so a
  // set-then-clear pulse shorter than a frame still sends exactly one
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_pend <= 1'b0;
    end else if (wr_ctrl && new_sbk && !send_break_request) begin
      brk_pend <= 1'b1;
    end else if (start_brk) begin
      brk_pend <= 1'b0;
    end
  end

  // a data write queues one frame; a second write before it starts
  // overwrites the byte, since nothing is buffered beyond one word
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_pend <= 1'b0;
    end else if (wr_data) begin
      data_pend <= 1'b1;
    end else if (start_data) begin
      data_pend <= 1'b0;
    end
  end

  // line register; a disabled transmitter leaves the line idle-high
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_data_o <= 1'b1;
    end else begin
      tx_data_o <= transmitter_enable ? line : 1'b1;
    end
  end

  // frame sequencer; load is a one-cycle strobe to the shifter
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      bit_cnt <= 5'h00;
      load <= 1'b0;
      pattern <= 13'h1FFF;
      brk_count <= 16'h0000;
    end else begin
      load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_idle) begin
            // idle goes first so the following break starts clean
            pattern <= 13'h1FFF;
            bit_cnt <= frame_len(word_nine);
            load <= 1'b1;
            state <= ST_IDLEC;
          end else if (start_brk) begin
            // held request starts another break back to back
            pattern <= brk_pattern(brk_len(lin_master, word_nine));
            bit_cnt <= brk_len(lin_master, word_nine);
            load <= 1'b1;
            state <= ST_BRK;
          end else if (start_data) begin
            pattern <= data_pattern(word_nine, data_hold);
            bit_cnt <= frame_len(word_nine);
            load <= 1'b1;
            state <= ST_DATA;
          end
        end
        ST_IDLEC, ST_DATA: begin
          if (tick) begin
            if (bit_cnt == 5'h01) state <= ST_IDLE;
            bit_cnt <= bit_cnt - 5'h01;
          end
        end
        ST_BRK: begin
          // line stays low the full count, no early exit on request clear
          if (tick) begin
            if (bit_cnt == 5'h01) begin
              brk_count <= brk_count + 16'h0001;
              state <= ST_STOP;
            end
            bit_cnt <= bit_cnt - 5'h01;
          end
        end
        ST_STOP: begin
          // shifter now shows ones: one full stop bit before the next frame
          if (tick) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // a disabled transmitter abandons idle and data frames at once;
      // a break in flight still counts out in full, though the line register already drives the line high
      if (!transmitter_enable && state != ST_IDLE && state != ST_BRK) begin
        state <= ST_IDLE;
      end
    end
  end
endmodule // sbig_tx

// ---- dv/sbig_tx_properties.sv ----
// port checker for the break and idle transmitter
`timescale 1ns/1ns
module sbig_tx_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire tx_data_o
);
  logic te, m, lin, arm, wr_ctl;
  logic [15:0] baud;
  int lo, hi, bt;
  assign wr_ctl = cyc_i && stb_i && we_i && ack_o && adr_i == 4'h0;
  assign bt = int'(baud) + 1;
  // shadow of control bits, plus low and high run lengths of the line
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {te, m, lin, arm, lo, hi} <= '0;
      baud <= 16'h0363;
    end else begin
      if (wr_ctl) begin
        {lin, m, te} <= {dat_i[3], dat_i[2], dat_i[0]};
      end
      if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h4) begin
        baud <= dat_i[15:0];
      end
      // arm only on enable off-to-on, cleared at the next falling edge
      arm <= (wr_ctl && dat_i[0] && !te) || (arm && tx_data_o);
      lo <= tx_data_o ? 0 : lo + 1;
      hi <= (!tx_data_o || (wr_ctl && dat_i[0] && !te)) ? 0 : hi + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence te_off;
    !te [*4];
  endsequence
  AST_BRK_SCI8: assert property ($rose(tx_data_o) && !m && !lin |-> lo == 10 * bt)
    else $error("break length wrong for 8-bit frames");
  AST_BRK_SCI9: assert property ($rose(tx_data_o) && m |-> lo == 11 * bt)
    else $error("break length wrong for 9-bit frames");
  AST_BRK_LIN: assert property ($rose(tx_data_o) && lin && !m |-> lo == 13 * bt)
    else $error("lin master break length wrong");
  AST_STOP: assert property ($fell(tx_data_o) |-> hi >= bt)
    else $error("line fell without a full stop bit");
  AST_IDLE: assert property ($fell(tx_data_o) && arm |-> hi >= (m ? 11 : 10) * bt)
    else $error("idle character too short");
  AST_TE_GATE: assert property (te_off |-> tx_data_o)
    else $error("line driven low with transmitter disabled");
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acked next cycle");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_UNMAPPED: assert property (ack_o && !we_i && adr_i == 4'h1 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // sbig_tx_checker

// ---- dv/sbig_node_model.sv ----
// remote node: measures each dominant run on the line in bit times
`timescale 1ns/1ns
module sbig_node_model #(
  parameter BT = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire rx_i,
  output reg brk_stb_o,
  output reg [7:0] brk_bits_o
);
  int lo;
  // no data frames are sent, so every low run is a break
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo <= 0;
      brk_stb_o <= 1'b0;
      brk_bits_o <= 8'h00;
    end else begin
      brk_stb_o <= rx_i && lo > 0;
      if (rx_i && lo > 0) brk_bits_o <= 8'(lo / BT);
      lo <= rx_i ? 0 : lo + 1;
    end
  end
endmodule // sbig_node_model

// ---- dv/tb_sbig_tx.sv ----
// testbench for the break and idle transmitter
`timescale 1ns/1ns
module tb_sbig_tx;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, tx_data_o, brk_stb;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0] brk_bits;
  logic [1:0] md;
  logic [31:0] rq[$];
  logic [7:0] bq[$];
  int n_fail, compares, seed, seen, strict;
  sbig_tx #(.BAUD_W(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_data_o(tx_data_o));
  sbig_node_model #(.BT(4)) node (.clk_i(clk_i), .rst_i(rst_i), .rx_i(tx_data_o),
    .brk_stb_o(brk_stb), .brk_bits_o(brk_bits));
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    // random upper lanes on control writes: only byte 0 may count there
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a,
      (a == 4'h0) ? {3'($random(seed)), 1'b1} : 4'hF, d};
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 20);
    {cyc_i, stb_i} <= 2'b00;
    if (k >= 20) begin n_fail++; test_done; end
    @(posedge clk_i);
  endtask
  task wait_seen(input int n);
    int k;
    k = 0;
    while (seen < n && k < 3000) begin @(posedge clk_i); k++; end
    if (seen < n) begin n_fail++; test_done; end
  endtask
  // oldest note against each result as it appears
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) chk("dat_o", rq.pop_front(), dat_o);
    if (brk_stb === 1'b1) begin
      seen++;
      if (bq.size() > 0) chk("break bits", {24'h0, bq.pop_front()}, {24'h0, brk_bits});
      else if (strict != 0) chk("extra break", 0, 1);
    end
  end
  initial begin
    {seed, n_fail, compares, seen, strict} = {32'd73, 32'd0, 32'd0, 32'd0, 32'd1};
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'b1000, 4'h0, 4'hF, 32'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rq.push_back(32'h0000_0363);
    wb(0, 4'h4, 32'h0);
    rq.push_back(32'h0);
    wb(0, 4'h1, 32'h0);
    wb(1, 4'h4, 32'h3);
    // every mode once, then random ones; idle then break, nothing between
    for (int i = 0; i < 6; i++) begin
      md = (i < 4) ? 2'(i) : 2'($random(seed));
      wb(1, 4'h0, {28'h0, md, 2'b00});
      repeat (4) @(posedge clk_i);
      wb(1, 4'h0, {28'h0, md, 2'b01});
      bq.push_back(md == 2'b10 ? 8'd13 : (md[0] ? 8'd11 : 8'd10));
      wb(1, 4'h0, {28'h0, md, 2'b11});
      wb(1, 4'h0, {28'h0, md, 2'b01});
      wait_seen(i + 1);
    end
    // held request repeats; last one may finish after clearing
    bq.push_back(8'd10);
    bq.push_back(8'd10);
    wb(1, 4'h0, 32'h3);
    wait_seen(8);
    wb(1, 4'h0, 32'h1);
    rq.push_back(32'h0000_0001);
    wb(0, 4'h0, 32'h0);
    strict = 0;
    repeat (200) @(posedge clk_i);
    test_done;
  end
endmodule // tb_sbig_tx
bind sbig_tx sbig_tx_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .tx_data_o(tx_data_o));
